/* File: verif/cdt_pin_model.sv */
// Pin-side partner: event source and pulled-up shared port pin
`timescale 1ns/1ps

module cdt_pin_model #(
  parameter int HOLD = 8
) (
  // Clock and stimulus request
  input  wire logic sys_clk,
  input  wire logic fall_req,
  // Shared pin as driven by the timer
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  // Pin levels seen by the timer
  output logic      event_pin,
  output logic      pin_level
);
  int low_cnt = 0;

  // Pull-up wins while the timer lets go of the pin
  assign pin_level = pin_oe_n ? 1'b1 : pin_out;

  // Event pin held low for HOLD cycles per request, idles high
  // Request taken at the rising edge, well after the bench set it
  always @(posedge sys_clk) begin
    if (fall_req) begin
      low_cnt <= HOLD;
    end else if (low_cnt > 0) begin
      low_cnt <= low_cnt - 1;
    end
  end
  assign event_pin = (low_cnt == 0);
endmodule // cdt_pin_model

/* File: verif/tb_cascaded_down_timer_pair.sv */
// Self-checking bench of the cascaded down-timer pair
`timescale 1ns/1ps

module tb_cascaded_down_timer_pair
  import cdt_pkg::*;
;
  logic sys_clk = 0, reset = 1, ev_fall = 0;
  logic start_0, pulse_en_0, irq_ack_0, irq_clr_0;
  logic start_1, pulse_en_1, irq_ack_1, irq_clr_1;
  cdt_mode_t mode_0, mode_1;
  logic [15:0] reload_0, reload_1, count_0, count_1;
  logic running_1, irq_0, irq_1, ev_pin, sh_in;
  logic sh_out, sh_oe_n, sh_lvl, os_pin;
  int errors = 0, cmp_count = 0, cycles = 0;

  cdt_timer_pair DUT (.sys_clk(sys_clk), .reset(reset), .start_0(start_0),
    .mode_0(mode_0), .reload_0(reload_0), .pulse_en_0(pulse_en_0),
    .irq_ack_0(irq_ack_0), .irq_clr_0(irq_clr_0), .start_1(start_1),
    .mode_1(mode_1), .reload_1(reload_1), .pulse_en_1(pulse_en_1),
    .irq_ack_1(irq_ack_1), .irq_clr_1(irq_clr_1), .count_0(count_0),
    .count_1(count_1), .running_1(running_1), .irq_0(irq_0), .irq_1(irq_1),
    .event_input_pin(ev_pin), .shared_port_pin_in(sh_in),
    .shared_port_pin_out(sh_out), .shared_port_pin_oe_n(sh_oe_n),
    .shared_port_level(sh_lvl), .oneshot_output_pin(os_pin));

  cdt_pin_model PINS (.sys_clk(sys_clk), .fall_req(ev_fall), .pin_out(sh_out),
    .pin_oe_n(sh_oe_n), .event_pin(ev_pin), .pin_level(sh_in));

  ////////////////////////////////////////////////////////////////////////////
  // Clock, timeout, checking and closing
  initial forever #2 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      test_done();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Pulse one control for a single cycle, taken at the next rising edge
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge sys_clk);
    s = 1'b0;
  endtask

  // Reset held for two cycles with all controls idle
  task automatic do_reset();
    reset = 1'b1;
    {start_0, pulse_en_0, irq_ack_0, irq_clr_0} = 4'h0;
    {start_1, pulse_en_1, irq_ack_1, irq_clr_1} = 4'h0;
    mode_0 = cdt_mode_timer;
    mode_1 = cdt_mode_timer;
    reload_0 = 16'h0000;
    reload_1 = 16'h0000;
    repeat (2) @(negedge sys_clk);
    reset = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_timer();
    int i;
    logic p;
    reload_0 = 16'h0002;
    pulse_en_0 = 1'b1;
    repeat (3) @(negedge sys_clk);
    chk("count_0 idle", 16'h0002, count_0);
    chk("oe_n on", 16'h0000, sh_oe_n);
    start_0 = 1'b1;
    for (i = 0; i < 20 && count_0 !== 16'h0001; i++) @(negedge sys_clk);
    @(negedge sys_clk);
    chk("count_0 step", 16'h0000, count_0);
    chk("irq_0 early", 16'h0000, irq_0);
    p = sh_out;
    @(negedge sys_clk);
    chk("count_0 reload", 16'h0002, count_0);
    chk("irq_0 set", 16'h0001, irq_0);
    chk("pulse out", {15'h0000, ~p}, sh_out);
    pulse(irq_ack_0);
    chk("irq_0 ack", 16'h0000, irq_0);
    for (i = 0; i < 10 && irq_0 !== 1'b1; i++) @(negedge sys_clk);
    start_0 = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk("irq_0 held", 16'h0001, irq_0);
    chk("count_0 stop", 16'h0002, count_0);
    pulse(irq_clr_0);
    chk("irq_0 clr", 16'h0000, irq_0);
    pulse_en_0 = 1'b0;
    @(negedge sys_clk);
    chk("oe_n off", 16'h0001, sh_oe_n);
    chk("out off", 16'h0000, sh_out);
    repeat (6) @(negedge sys_clk);
    chk("pin pulled", 16'h0001, sh_lvl);
  endtask

  task automatic t_event();
    int i, k;
    do_reset();
    mode_0 = cdt_mode_event;
    start_0 = 1'b1;
    repeat (4) @(negedge sys_clk);
    for (k = 0; k < 2; k++) begin
      chk("irq_0 quiet", 16'h0000, irq_0);
      pulse(ev_fall);
      for (i = 0; i < 10 && irq_0 !== 1'b1; i++) @(negedge sys_clk);
      chk("irq_0 fall", 16'h0001, irq_0);
      pulse(irq_clr_0);
      repeat (14) @(negedge sys_clk);
    end
    chk("one event", 16'h0000, irq_0);
  endtask

  task automatic t_cascade();
    int i, n;
    logic [15:0] prev;
    do_reset();
    reload_0 = 16'h0001;
    mode_1 = cdt_mode_event;
    reload_1 = 16'h0002;
    // Stopped counters take their presets first
    @(negedge sys_clk);
    {start_0, start_1} = 2'b11;
    n = 0;
    prev = 16'h0001;
    for (i = 0; i < 40 && irq_1 !== 1'b1; i++) begin
      @(negedge sys_clk);
      if (prev === 16'h0000 && count_0 === 16'h0001) n++;
      prev = count_0;
    end
    chk("t0 underflows", 16'h0003, n[15:0]);
    chk("count_1 reload", 16'h0002, count_1);
  endtask

  task automatic t_oneshot();
    int i, w;
    do_reset();
    reload_0 = 16'h0004;
    mode_1 = cdt_mode_oneshot;
    reload_1 = 16'h0003;
    pulse_en_1 = 1'b1;
    // Stopped counters take their presets first
    @(negedge sys_clk);
    {start_0, start_1} = 2'b11;
    for (i = 0; i < 20 && os_pin !== 1'b1; i++) @(negedge sys_clk);
    chk("os high", 16'h0001, os_pin);
    chk("running_1", 16'h0001, running_1);
    chk("irq_1 early", 16'h0000, irq_1);
    for (w = 0; w < 20 && os_pin === 1'b1; w++) @(negedge sys_clk);
    chk("os width", 16'h0003, w[15:0]);
    chk("irq_1 end", 16'h0001, irq_1);
    chk("running_1 end", 16'h0000, running_1);
    chk("count_1 end", 16'h0003, count_1);
    pulse(irq_ack_1);
    chk("irq_1 ack", 16'h0000, irq_1);
  endtask

  // Timer 1 in timer mode triggers a timer 0 one-shot on the shared pin
  task automatic t_oneshot0();
    int i, w;
    do_reset();
    mode_0 = cdt_mode_oneshot;
    reload_0 = 16'h0002;
    pulse_en_0 = 1'b1;
    reload_1 = 16'h0003;
    @(negedge sys_clk);
    {start_0, start_1} = 2'b11;
    for (i = 0; i < 20 && sh_out !== 1'b1; i++) @(negedge sys_clk);
    chk("irq_1 timer", 16'h0001, irq_1);
    chk("shared os high", 16'h0001, sh_out);
    chk("shared os oe_n", 16'h0000, sh_oe_n);
    for (w = 0; w < 20 && sh_out === 1'b1; w++) @(negedge sys_clk);
    chk("shared os width", 16'h0002, w[15:0]);
    chk("irq_0 os end", 16'h0001, irq_0);
    chk("count_0 os end", 16'h0002, count_0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    do_reset();
    t_timer();
    t_event();
    t_cascade();
    t_oneshot();
    t_oneshot0();
    test_done();
  end
endmodule // tb_cascaded_down_timer_pair

/* File: verilog/cdt_channel.sv */
// One 16-bit reloadable down-counting timer channel
`timescale 1ns/1ps
`include "cdt_timer_regs.svh"

module cdt_channel
  import cdt_pkg::*;
#(
  parameter int W = `CDT_WIDTH
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset,
  // Control
  input  wire logic         start,
  input  wire cdt_mode_t    mode,
  input  wire logic [W-1:0] reload,
  input  wire logic         pulse_en,
  // Count events and trigger
  input  wire logic         event_tick,
  input  wire logic         trigger,
  // Request flag clearing
  input  wire logic         irq_ack,
  input  wire logic         irq_clr,
  // Status
  output logic      [W-1:0] count,
  output logic              running,
  output logic              underflow,
  output logic              out_level,
  output logic              irq
);

  logic [W-1:0] cnt_reg, cnt_next;
  logic         run_reg, run_next;
  logic         out_reg, out_next;
  logic         irq_reg, irq_next;
  logic         tick;

  ////////////////////////////////////////////////////////////////////////////
  // Next state of counter, one-shot run, output and request flag
  always_comb begin
    cnt_next  = cnt_reg;
    run_next  = run_reg;
    out_next  = out_reg;
    irq_next  = irq_reg & ~(irq_ack | irq_clr);
    underflow = 1'b0;
    tick      = 1'b0;
    unique case (mode)
      cdt_mode_timer:   tick = 1'b1;
      cdt_mode_event:   tick = event_tick;
      cdt_mode_oneshot: tick = run_reg;
      default:          tick = 1'b0;       // Illegal code holds
    endcase
    if (!start) begin
      // Stopped: counter preset follows reload
      cnt_next = reload;
      run_next = 1'b0;
      out_next = 1'b0;
    end else if (mode == cdt_mode_oneshot) begin
      if (!run_reg) begin
        if (trigger) begin
          run_next = 1'b1;
          out_next = pulse_en;
        end
      end else if (cnt_reg <= `CDT_CNT_ONE) begin
        // Count at one or zero: end of the one-shot
        run_next  = 1'b0;
        out_next  = 1'b0;
        cnt_next  = reload;
        irq_next  = 1'b1;
        underflow = 1'b1;
      end else begin
        cnt_next = cnt_reg - `CDT_CNT_ONE;
      end
    end else if (tick) begin
      if (cnt_reg == `CDT_CNT_ZERO) begin
        // Underflow: reload and keep counting
        cnt_next  = reload;
        irq_next  = 1'b1;
        underflow = 1'b1;
        out_next  = pulse_en & ~out_reg;
      end else begin
        cnt_next = cnt_reg - `CDT_CNT_ONE;
      end
    end
    if (!pulse_en) begin
      out_next = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      cnt_reg <= `CDT_CNT_ZERO;
      run_reg <= `CDT_FLAG_RESET;
      out_reg <= `CDT_FLAG_RESET;
      irq_reg <= `CDT_FLAG_RESET;
    end else begin
      cnt_reg <= cnt_next;
      run_reg <= run_next;
      out_reg <= out_next;
      irq_reg <= irq_next;
    end
  end

  assign count     = cnt_reg;
  assign running   = run_reg;
  assign out_level = out_reg;
  assign irq       = irq_reg;

endmodule // cdt_channel

/* File: verilog/cdt_pkg.sv */
// Types shared by the cascaded down-timer pair
package cdt_pkg;

  // Operating mode of one timer
  typedef enum logic [1:0] {
    cdt_mode_timer,
    cdt_mode_event,
    cdt_mode_oneshot
  } cdt_mode_t;

endpackage

/* File: verilog/cdt_timer_pair.sv */
// Pair of cascadable 16-bit down timers with pin sampling and outputs
//
// Overview of operation
// - Counting runs only while start flag is one
// - Timer mode decrements every undivided source pulse
// - Underflow reloads, continues, sets request bit
// - Second timer can count first timer underflows
// - First timer underflow triggers second one-shot
// - One-shot output goes high when counting starts
// - One-shot at count one: output low, reload, stop, request
// - Pulse select drives underflow pulses onto pin
// - Pulse deselect returns shared pin to input
// - Pulse output independent of interrupt enabling
// - Event mode, zero count: each fall interrupts
`timescale 1ns/1ps
`include "cdt_timer_regs.svh"

module cdt_timer_pair
  import cdt_pkg::*;
#(
  parameter int W = `CDT_WIDTH
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset,
  // Timer 0 control
  input  wire logic         start_0,
  input  wire cdt_mode_t    mode_0,
  input  wire logic [W-1:0] reload_0,
  input  wire logic         pulse_en_0,
  input  wire logic         irq_ack_0,
  input  wire logic         irq_clr_0,
  // Timer 1 control
  input  wire logic         start_1,
  input  wire cdt_mode_t    mode_1,
  input  wire logic [W-1:0] reload_1,
  input  wire logic         pulse_en_1,
  input  wire logic         irq_ack_1,
  input  wire logic         irq_clr_1,
  // Status
  output logic      [W-1:0] count_0,
  output logic      [W-1:0] count_1,
  output logic              running_1,
  output logic              irq_0,
  output logic              irq_1,
  // Pins
  input  wire logic         event_input_pin,
  input  wire logic         shared_port_pin_in,
  output logic              shared_port_pin_out,
  output logic              shared_port_pin_oe_n,
  output logic              shared_port_level,
  output logic              oneshot_output_pin
);

  logic [`CDT_PINS-1:0] s1_reg, s2_reg, s3_reg;
  logic [`CDT_PINS-1:0] lvl_reg, lvl_next;
  logic                 fall_reg, fall_next;
  logic                 uf_0, uf_1;
  logic                 out_0, run_0;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling: change accepted once stages two and three agree
  always_comb begin
    lvl_next  = lvl_reg;
    fall_next = 1'b0;
    for (int i = 0; i < `CDT_PINS; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        lvl_next[i] = s3_reg[i];
      end
    end
    // One event per falling edge of the event input
    fall_next = lvl_reg[`CDT_PIN_EVENT]
              & ~lvl_next[`CDT_PIN_EVENT];
  end

  // Sampling registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      s1_reg   <= `CDT_PINS_IDLE;
      s2_reg   <= `CDT_PINS_IDLE;
      s3_reg   <= `CDT_PINS_IDLE;
      lvl_reg  <= `CDT_PINS_IDLE;
      fall_reg <= `CDT_FLAG_RESET;
    end else begin
      s1_reg   <= {shared_port_pin_in, event_input_pin};
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      lvl_reg  <= lvl_next;
      fall_reg <= fall_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer 0: counts pin falls in event mode
  cdt_channel #(
    .W          (W)
  ) u_timer_0 (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .start      (start_0),
    .mode       (mode_0),
    .reload     (reload_0),
    .pulse_en   (pulse_en_0),
    .event_tick (fall_reg),
    .trigger    (uf_1),
    .irq_ack    (irq_ack_0),
    .irq_clr    (irq_clr_0),
    .count      (count_0),
    .running    (run_0),
    .underflow  (uf_0),
    .out_level  (out_0),
    .irq        (irq_0)
  );

  // Timer 1: cascaded on timer 0 underflows
  cdt_channel #(
    .W          (W)
  ) u_timer_1 (
    .sys_clk    (sys_clk),
    .reset      (reset),
    .start      (start_1),
    .mode       (mode_1),
    .reload     (reload_1),
    .pulse_en   (pulse_en_1),
    .event_tick (uf_0),
    .trigger    (uf_0),
    .irq_ack    (irq_ack_1),
    .irq_clr    (irq_clr_1),
    .count      (count_1),
    .running    (running_1),
    .underflow  (uf_1),
    .out_level  (oneshot_output_pin),
    .irq        (irq_1)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Shared pin: timer output when selected, else input
  assign shared_port_pin_out  = out_0;
  assign shared_port_pin_oe_n = ~pulse_en_0;
  assign shared_port_level    = lvl_reg[`CDT_PIN_PORT];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_stop_holds: assert property (
    @(posedge sys_clk) disable iff (reset)
    !start_0 |=> count_0 == $past(reload_0))
    else $error("stopped timer 0 did not hold its preset");

  a_timer_decrement: assert property (
    @(posedge sys_clk) disable iff (reset)
    start_0 && $past(start_0) && mode_0 == cdt_mode_timer
      && count_0 != `CDT_CNT_ZERO
    |=> count_0 == $past(count_0) - `CDT_CNT_ONE)
    else $error("timer 0 did not decrement by one");

  a_underflow_reload: assert property (
    @(posedge sys_clk) disable iff (reset)
    start_0 && $past(start_0) && mode_0 == cdt_mode_timer
      && count_0 == `CDT_CNT_ZERO
    |=> count_0 == $past(reload_0) && irq_0)
    else $error("timer 0 underflow missed reload or request");

  a_cascade_count: assert property (
    @(posedge sys_clk) disable iff (reset)
    start_1 && $past(start_1) && mode_1 == cdt_mode_event
      && count_1 != `CDT_CNT_ZERO
    |-> ##1 count_1 == $past(count_1) - {{(W-1){1'b0}}, $past(uf_0)})
    else $error("timer 1 did not follow timer 0 underflows");

  a_oneshot_trigger: assert property (
    @(posedge sys_clk) disable iff (reset)
    start_1 && mode_1 == cdt_mode_oneshot && !running_1 && uf_0
    |=> running_1)
    else $error("timer 1 one-shot ignored its trigger");

  a_oneshot_high: assert property (
    @(posedge sys_clk) disable iff (reset)
    $rose(running_1) && pulse_en_1 && $past(pulse_en_1) |-> oneshot_output_pin)
    else $error("one-shot output not high at start");

  a_oneshot_end: assert property (
    @(posedge sys_clk) disable iff (reset)
    running_1 && start_1 && mode_1 == cdt_mode_oneshot
      && count_1 <= `CDT_CNT_ONE && !irq_ack_1 && !irq_clr_1
    |=> !running_1 && !oneshot_output_pin && irq_1
      && count_1 == $past(reload_1))
    else $error("one-shot end missed stop, low, reload or request");

  // Timer 0 one-shot, triggered by timer 1 underflow, output on shared pin
  a_os0_trigger: assert property (
    @(posedge sys_clk) disable iff (reset)
    start_0 && mode_0 == cdt_mode_oneshot && !run_0 && uf_1
    |=> run_0 && shared_port_pin_out == $past(pulse_en_0))
    else $error("timer 0 one-shot ignored its trigger");

  a_os0_end: assert property (
    @(posedge sys_clk) disable iff (reset)
    run_0 && start_0 && mode_0 == cdt_mode_oneshot
      && count_0 <= `CDT_CNT_ONE
    |=> !run_0 && !shared_port_pin_out && irq_0
      && count_0 == $past(reload_0))
    else $error("timer 0 one-shot end incomplete");

  a_pulse_toggle: assert property (
    @(posedge sys_clk) disable iff (reset)
    pulse_en_0 && start_0 && mode_0 == cdt_mode_timer && uf_0
    |=> !shared_port_pin_oe_n && shared_port_pin_out != $past(out_0)
      || !pulse_en_0)
    else $error("underflow pulse not driven on shared pin");

  a_pin_released: assert property (
    @(posedge sys_clk) disable iff (reset)
    !pulse_en_0 |-> shared_port_pin_oe_n ##1 !shared_port_pin_out)
    else $error("shared pin still driven after deselect");

  a_event_zero: assert property (
    @(posedge sys_clk) disable iff (reset)
    start_0 && $past(start_0) && mode_0 == cdt_mode_event
      && count_0 == `CDT_CNT_ZERO && fall_reg && !irq_ack_0 && !irq_clr_0
    |=> irq_0)
    else $error("event fall at zero count raised no request");

  a_irq_sticky: assert property (
    @(posedge sys_clk) disable iff (reset)
    irq_1 && !irq_ack_1 && !irq_clr_1 |=> irq_1)
    else $error("request bit dropped without clear");

  a_fall_single: assert property (
    @(posedge sys_clk) disable iff (reset)
    fall_reg |=> !fall_reg)
    else $error("one falling edge counted twice");

endmodule // cdt_timer_pair

/* File: verilog/cdt_timer_regs.svh */
// Constants of the cascaded down-timer pair
`ifndef CDT_TIMER_REGS_SVH
`define CDT_TIMER_REGS_SVH

`define CDT_WIDTH      16
`define CDT_CNT_ZERO   16'h0000
`define CDT_CNT_ONE    16'h0001
`define CDT_FLAG_RESET 1'b0
`define CDT_PINS       2
`define CDT_PIN_EVENT  0
`define CDT_PIN_PORT   1
`define CDT_PINS_IDLE  2'h3

`endif
